// file: shared/mscio_defines.vh
// constants for the motor starter control input/output logic
// assumes a 50 MHz system clock; included by mscio_top.v
`ifndef MSCIO_DEFINES_VH
`define MSCIO_DEFINES_VH

// ---------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------
`define MSCIO_CLK_HZ          50000000
`define MSCIO_DEBOUNCE_MS     10
`define MSCIO_DEBOUNCE_CYC    ((`MSCIO_CLK_HZ / 1000) * `MSCIO_DEBOUNCE_MS)
`define MSCIO_ATSPEED_MAX_S   30
`define MSCIO_ATSPEED_MAX_CYC (`MSCIO_CLK_HZ * `MSCIO_ATSPEED_MAX_S)
`define MSCIO_CNT_W           32
`define MSCIO_DEB_IDLE        7'h26    // settled contact levels after reset

// ---------------------------------------------------------------------
// relay function codes
// ---------------------------------------------------------------------
`define MSCIO_FN_W            5
`define MSCIO_FN_OFF          5'h00
`define MSCIO_FN_RUN          5'h01
`define MSCIO_FN_ATSPEED      5'h02
`define MSCIO_FN_THERM        5'h03
`define MSCIO_FN_JOG          5'h04
`define MSCIO_FN_RAMP_TWO     5'h05
`define MSCIO_FN_ANY_TRIP     5'h10
`define MSCIO_RLY1_DEFAULT    5'h01
`define MSCIO_RLY2_DEFAULT    5'h02
`define MSCIO_RLY3_DEFAULT    5'h10

// ---------------------------------------------------------------------
// trip codes and ramp figures
// ---------------------------------------------------------------------
`define MSCIO_TRIP_W          4
`define MSCIO_TRIP_NONE       4'h0
`define MSCIO_TRIP_FIRST      4'h5
`define MSCIO_TRIP_LAST       4'hF
`define MSCIO_THERM_TRIP_CODE 4'hE
`define MSCIO_RAMP_W          10
`define MSCIO_FULL_V_TIME     10'h000
`define MSCIO_FULL_V_CURR     10'h258

// ---------------------------------------------------------------------
// serial control modes
// ---------------------------------------------------------------------
`define MSCIO_SER_W           2
`define MSCIO_SER_OFF         2'h0
`define MSCIO_SER_FULL        2'h1
`define MSCIO_SER_JOG_ENABLE  2'h2
`define MSCIO_SER_JOG_LOCK    2'h3

`endif

// file: hdl/mscio_top.v
// discrete control input and output logic of a motor soft starter
// assumes all inputs synchronous to clk_sys; contacts read 1 when closed
// timing counts default to real time; a bench may pass shorter ones
`timescale 1ns/1ns
`default_nettype none
`include "mscio_defines.vh"

module mscio_top #(
    parameter [`MSCIO_CNT_W-1:0] DEBOUNCE_CYC = `MSCIO_DEBOUNCE_CYC,
    parameter [`MSCIO_CNT_W-1:0] ATSPEED_CYC  = `MSCIO_ATSPEED_MAX_CYC
) (
    input  wire                     clk_sys,
    input  wire                     nrst,
    input  wire                     two_wire_mode,
    input  wire                     start_in,
    input  wire                     stop_in,
    input  wire                     interlock_in,
    input  wire                     ramp_sel_in,
    input  wire                     jog_in,
    input  wire                     thermistor_loop_ok,
    input  wire                     reset_req,
    input  wire                     decel_enable,
    input  wire                     decel_done,
    input  wire                     end_of_ramp,
    input  wire                     current_dropped,
    input  wire                     ext_trip,
    input  wire [`MSCIO_TRIP_W-1:0] ext_trip_code,
    input  wire                     serial_run_req,
    input  wire [`MSCIO_SER_W-1:0]  serial_control_mode_param,
    input  wire [`MSCIO_FN_W-1:0]   relay_one_function,
    input  wire [`MSCIO_FN_W-1:0]   relay_two_function,
    input  wire [`MSCIO_FN_W-1:0]   relay_three_function,
    input  wire [`MSCIO_RAMP_W-1:0] ramp_one_time,
    input  wire [`MSCIO_RAMP_W-1:0] ramp_one_curr,
    input  wire [`MSCIO_RAMP_W-1:0] ramp_two_time,
    input  wire [`MSCIO_RAMP_W-1:0] ramp_two_curr,
    output reg                      motor_power,
    output reg                      ramping,
    output reg                      decelerating,
    output reg                      full_voltage_start,
    output reg                      ramp_two_active,
    output reg                      jog_active,
    output reg                      serial_enabled,
    output reg                      at_speed,
    output reg                      bypass_cmd,
    output reg                      fault_out,
    output reg  [`MSCIO_TRIP_W-1:0] trip_code,
    output reg  [2:0]               aux_relay
);

    // -----------------------------------------------------------------
    // states of the run sequence
    // -----------------------------------------------------------------
    localparam [4:0] ST_IDLE  = 5'h01;
    localparam [4:0] ST_RAMP  = 5'h02;
    localparam [4:0] ST_RUN   = 5'h04;
    localparam [4:0] ST_DECEL = 5'h08;
    localparam [4:0] ST_TRIP  = 5'h10;

    localparam NIN = 7;
    // idle levels: normally closed stop, interlock and loop read closed,
    // so leaving reset raises no false stop, refusal or trip
    localparam [NIN-1:0] DEB_IDLE = `MSCIO_DEB_IDLE;

    // -----------------------------------------------------------------
    // input debounce
    // -----------------------------------------------------------------
    wire [NIN-1:0] raw_in;
    wire [NIN-1:0] deb;

    assign raw_in = {reset_req, thermistor_loop_ok, jog_in, ramp_sel_in,
                     interlock_in, stop_in, start_in};

    // each input must hold a new level for the debounce time; a bounce
    // back to the settled level restarts the count
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi = gi + 1) begin : g_deb
            reg [`MSCIO_CNT_W-1:0] cnt;
            reg                    lvl;
            always @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    cnt        <= {`MSCIO_CNT_W{1'b0}};
                    lvl        <= DEB_IDLE[gi];
                end else if (raw_in[gi] == lvl) begin
                    cnt        <= {`MSCIO_CNT_W{1'b0}};
                end else if (cnt >= DEBOUNCE_CYC - 1) begin
                    cnt        <= {`MSCIO_CNT_W{1'b0}};
                    lvl        <= raw_in[gi];
                end else begin
                    cnt        <= cnt + 1'b1;
                end
            end
            assign deb[gi] = lvl;
        end
    endgenerate

    // debounced contacts under readable names
    wire d_start  = deb[0];
    wire d_stop   = deb[1];  // normally closed: 1 means not pressed
    wire d_intlk  = deb[2];  // normally closed: 1 means healthy
    wire d_ramp2  = deb[3];
    wire d_jog    = deb[4];
    wire d_therm  = deb[5];  // 1 means loop intact
    wire d_reset  = deb[6];

    // -----------------------------------------------------------------
    // relay function decode
    // -----------------------------------------------------------------
    // one relay's output for its function code; unknown codes stay open
    function relay_fn;
        input [`MSCIO_FN_W-1:0] fn;
        input                   run_f;
        input                   spd_f;
        input                   thr_f;
        input                   jog_f;
        input                   r2_f;
        input                   trp_f;
        begin
            case (fn)
                `MSCIO_FN_RUN:      relay_fn = run_f;
                `MSCIO_FN_ATSPEED:  relay_fn = spd_f;
                `MSCIO_FN_THERM:    relay_fn = thr_f;
                `MSCIO_FN_JOG:      relay_fn = jog_f;
                `MSCIO_FN_RAMP_TWO: relay_fn = r2_f;
                `MSCIO_FN_ANY_TRIP: relay_fn = trp_f;
                default:            relay_fn = 1'b0;
            endcase
        end
    endfunction

    // -----------------------------------------------------------------
    // run request
    // -----------------------------------------------------------------
    reg        seal_in;
    reg  [4:0] state;
    reg  [4:0] next_state;
    reg  [`MSCIO_CNT_W-1:0] spd_cnt;
    reg  [`MSCIO_TRIP_W-1:0] next_trip_code;
    wire       serial_start;
    wire       run_req;
    wire       therm_trip;

    // three-wire seal-in holds the start until stop opens
    // a trip or open interlock also drops it, so no restart follows a reset
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            seal_in <= 1'b0;
        end else if (!d_stop || state == ST_TRIP || !d_intlk) begin
            seal_in <= 1'b0;
        end else if (d_start && !two_wire_mode) begin
            seal_in <= 1'b1;
        end
    end

    // serial port may start only where the mode and jog input allow it
    assign serial_start = serial_enabled && serial_run_req;

    // serial start joins the request under either wiring style
    // two-wire: the maintained contact between start and stop terminals
    assign run_req = (two_wire_mode ? (d_start && d_stop) : seal_in)
                     || serial_start;

    // open thermistor or protection loop is an immediate trip
    assign therm_trip = !d_therm;

    // -----------------------------------------------------------------
    // state sequencing
    // -----------------------------------------------------------------
    // next state and next trip code; the trip sources are applied last
    always @* begin
        next_state     = state;
        next_trip_code = trip_code;
        case (state)
            ST_IDLE: begin
                if (run_req && d_intlk)
                    next_state = ST_RAMP;
            end
            ST_RAMP, ST_RUN: begin
                if (!d_intlk) begin
                    // an open interlock drops power at once, no decel
                    next_state = ST_IDLE;
                end else if (!run_req) begin
                    next_state = decel_enable ? ST_DECEL : ST_IDLE;
                end else if (state == ST_RAMP &&
                             ((end_of_ramp && current_dropped) ||
                              spd_cnt >= ATSPEED_CYC - 1)) begin
                    next_state = ST_RUN;
                end
            end
            ST_DECEL: begin
                // a new run request during decel restarts the ramp
                if (decel_done || !d_intlk)
                    next_state = ST_IDLE;
                else if (run_req && d_intlk)
                    next_state = ST_RAMP;
            end
            ST_TRIP: begin
                // leave trip only once both trip sources have cleared
                if (d_reset && !therm_trip && !ext_trip) begin
                    next_state     = ST_IDLE;
                    next_trip_code = `MSCIO_TRIP_NONE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        // trips override every state, deceleration included
        // the loop trip is tested first, so its code wins over an external one
        if (therm_trip) begin
            next_state     = ST_TRIP;
            next_trip_code = `MSCIO_THERM_TRIP_CODE;
        end else if (ext_trip && state != ST_TRIP) begin
            next_state     = ST_TRIP;
            next_trip_code = ext_trip_code;
        end
    end

    // state, at-speed timer and trip code registers
    // the at-speed timer counts only while the ramp goes on; any other
    // state clears it, so every restart gets the full limit
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state     <= ST_IDLE;
            spd_cnt   <= {`MSCIO_CNT_W{1'b0}};
            trip_code <= `MSCIO_TRIP_NONE;
        end else begin
            state     <= next_state;
            trip_code <= next_trip_code;
            if (next_state == ST_RAMP && state == ST_RAMP)
                spd_cnt <= spd_cnt + 1'b1;
            else
                spd_cnt <= {`MSCIO_CNT_W{1'b0}};
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    // flags from the next state, so registered outputs move with the state
    wire trip_hi       = (next_trip_code >= `MSCIO_TRIP_FIRST) &&
                         (next_trip_code <= `MSCIO_TRIP_LAST);
    wire run_flag      = (next_state == ST_RAMP) || (next_state == ST_RUN);
    wire spd_flag      = (next_state == ST_RUN);
    wire thr_flag      = (next_state == ST_TRIP) &&
                         (next_trip_code == `MSCIO_THERM_TRIP_CODE);
    wire trp_flag      = (next_state == ST_TRIP);
    // active ramp settings follow the ramp-select contact
    wire [`MSCIO_RAMP_W-1:0] act_time = d_ramp2 ? ramp_two_time : ramp_one_time;
    wire [`MSCIO_RAMP_W-1:0] act_curr = d_ramp2 ? ramp_two_curr : ramp_one_curr;

    // -----------------------------------------------------------------
    // programmable auxiliary relays
    // -----------------------------------------------------------------
    wire [3*`MSCIO_FN_W-1:0] fn_all;
    wire [2:0]               trip_sel;
    wire [2:0]               next_aux;

    // relay three's any-trip is narrowed to codes five to fifteen;
    // relays one and two report every trip, like the fault output
    assign fn_all   = {relay_three_function, relay_two_function,
                       relay_one_function};
    assign trip_sel = {trp_flag && trip_hi, trp_flag, trp_flag};

    // each relay decodes its own function code from the same flags, except its own trip_sel bit;
    // run_flag drops at start of decel, so relay one opens then
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_aux
            assign next_aux[gi] = relay_fn(fn_all[gi*`MSCIO_FN_W +: `MSCIO_FN_W],
                                           run_flag, spd_flag, thr_flag,
                                           jog_active, ramp_two_active,
                                           trip_sel[gi]);
        end
    endgenerate

    // registered outputs follow the next state
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            motor_power        <= 1'b0;
            ramping            <= 1'b0;
            decelerating       <= 1'b0;
            full_voltage_start <= 1'b0;
            ramp_two_active    <= 1'b0;
            jog_active         <= 1'b0;
            serial_enabled     <= 1'b0;
            at_speed           <= 1'b0;
            bypass_cmd         <= 1'b0;
            fault_out          <= 1'b0;
            aux_relay          <= 3'h0;
        end else begin
            // thermistor trip makes next_state trip, so power drops at once
            motor_power  <= run_flag || (next_state == ST_DECEL);
            ramping      <= (next_state == ST_RAMP);
            decelerating <= (next_state == ST_DECEL);
            at_speed     <= spd_flag;
            bypass_cmd   <= spd_flag;
            // ramp choice is frozen once the start begins, so a switch
            // during the ramp cannot swap profiles halfway
            if (state == ST_IDLE) begin
                ramp_two_active    <= d_ramp2;
                full_voltage_start <= (act_time == `MSCIO_FULL_V_TIME) &&
                                      (act_curr == `MSCIO_FULL_V_CURR);
            end
            // jog only with a start request present
            jog_active   <= d_jog && run_flag && run_req;
            // serial permission follows the mode and the debounced jog contact
            case (serial_control_mode_param)
                `MSCIO_SER_FULL:       serial_enabled <= 1'b1;
                `MSCIO_SER_JOG_ENABLE: serial_enabled <= d_jog;
                `MSCIO_SER_JOG_LOCK:   serial_enabled <= !d_jog;
                default:               serial_enabled <= 1'b0;
            endcase
            // fault output is fixed to any trip and cannot be reassigned
            fault_out    <= trp_flag;
            aux_relay    <= next_aux;
        end
    end

endmodule // mscio_top
`default_nettype wire

// file: dv/mscio_field.sv
// far side model: start contact, stop button, overload loop
// assumes clk_sys from bench; 1 means contact closed
`timescale 1ns/1ns
`default_nettype none
module mscio_field (
    input  wire clk_sys,
    input  wire start_req,
    input  wire stop_req,
    input  wire olr_trip,
    input  wire olr_reset,
    output reg  start_in = 1'b0,
    output reg  stop_in = 1'b1,
    output reg  thermistor_loop_ok = 1'b1
);
    reg       last_req = 1'b0;
    reg [1:0] bnc      = 2'h0;
    reg       olr_open = 1'b0;
    // start contact chatters on each change, then settles
    always @(posedge clk_sys) begin
        last_req <= start_req;
        if (start_req != last_req) begin
            bnc <= 2'h3;
            start_in <= ~start_in;
        end else if (bnc != 2'h0) begin
            bnc <= bnc - 2'h1;
            start_in <= ~start_in;
        end else begin
            start_in <= start_req;
        end
        stop_in <= ~stop_req;
    end
    // overload contact opens the loop until reset by hand
    always @(posedge clk_sys) begin
        if (olr_trip)
            olr_open <= 1'b1;
        else if (olr_reset)
            olr_open <= 1'b0;
        thermistor_loop_ok <= ~olr_open;
    end
endmodule // mscio_field
`default_nettype wire

// file: dv/mscio_sva.sv
// port checker for mscio_top
// assumes one clock domain, bound onto every mscio_top
`timescale 1ns/1ns
`default_nettype none
module mscio_sva #(
    parameter [31:0] DEBOUNCE_CYC = 32'h4,
    parameter [31:0] ATSPEED_CYC  = 32'h32
) (
    input wire       clk_sys,
    input wire       nrst,
    input wire       thermistor_loop_ok,
    input wire       interlock_in,
    input wire       reset_req,
    input wire       ext_trip,
    input wire [4:0] relay_one_function,
    input wire [4:0] relay_three_function,
    input wire       motor_power,
    input wire       ramping,
    input wire       decelerating,
    input wire       at_speed,
    input wire       bypass_cmd,
    input wire       fault_out,
    input wire [3:0] trip_code,
    input wire [2:0] aux_relay
);
    reg [31:0] rcnt;
    // length of the current ramp
    always @(posedge clk_sys or negedge nrst)
        if (!nrst)
            rcnt <= 32'h0;
        else
            rcnt <= ramping ? rcnt + 32'h1 : 32'h0;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    a_fault_any_trip: assert property (fault_out == (trip_code != 4'h0))
        else $error("fault output differs from trip state");
    a_interlock_stop: assert property (!interlock_in [*8] |-> !motor_power)
        else $error("motor runs with interlock open");
    a_therm_cut: assert property (!thermistor_loop_ok [*8] |-> !motor_power && trip_code == 4'hE)
        else $error("loop open without thermistor trip");
    a_trip_power_off: assert property (fault_out [*2] |-> !motor_power)
        else $error("motor powered during trip");
    a_relay_three: assert property (relay_three_function == 5'h10 && $stable(trip_code)
        |-> aux_relay[2] == (trip_code >= 4'h5))
        else $error("relay three wrong for trip");
    a_relay_one_run: assert property (relay_one_function == 5'h01 && $stable(relay_one_function)
        |-> aux_relay[0] == (motor_power && !decelerating))
        else $error("relay one wrong for run");
    a_bypass_at_speed: assert property (bypass_cmd |-> at_speed && motor_power)
        else $error("bypass without at-speed");
    a_ramp_max: assert property (rcnt <= ATSPEED_CYC + 32'h2)
        else $error("ramp outlasts at-speed limit");
    a_reset_clears: assert property ((reset_req && thermistor_loop_ok && !ext_trip) [*8]
        |-> trip_code == 4'h0)
        else $error("reset left trip set");
    cover property ($rose(at_speed));
    cover property ($rose(fault_out));
    cover property ($rose(decelerating));
endmodule // mscio_sva
bind mscio_top mscio_sva #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .ATSPEED_CYC(ATSPEED_CYC)) mscio_sva_i (
    .clk_sys(clk_sys), .nrst(nrst), .thermistor_loop_ok(thermistor_loop_ok),
    .interlock_in(interlock_in), .reset_req(reset_req), .ext_trip(ext_trip),
    .relay_one_function(relay_one_function), .relay_three_function(relay_three_function),
    .motor_power(motor_power), .ramping(ramping), .decelerating(decelerating),
    .at_speed(at_speed), .bypass_cmd(bypass_cmd), .fault_out(fault_out),
    .trip_code(trip_code), .aux_relay(aux_relay));
`default_nettype wire

// file: dv/mscio_top_test.sv
// self-checking bench for mscio_top with a model
// assumes mscio_field on the far side, 50 MHz clock
`timescale 1ns/1ns
`default_nettype none
`include "mscio_defines.vh"
module mscio_top_test;
    reg clk_sys = 1'b0, nrst = 1'b0, sreq = 1'b0, preq = 1'b0, otrip = 1'b0, orst = 1'b0;
    reg two_w = 1'b0, ilk = 1'b1, rsel = 1'b0, jog = 1'b0, rreq = 1'b0, decel = 1'b0;
    reg etrip = 1'b0, ddone = 1'b0, eor = 1'b0, cdrop = 1'b0, srun = 1'b0;
    reg [3:0] ecode = 4'h0;
    reg [1:0] smode = 2'h0;
    reg [4:0] fn1 = 5'h01;
    reg [9:0] r1t = 10'h00A, r1c = 10'h12C;
    wire start_in, stop_in, loop_ok, motor_power, ramping, decelerating, fvs, r2a;
    wire jog_active, ser_en, at_speed, bypass_cmd, fault_out;
    wire [3:0] trip_code;
    wire [2:0] aux;
    integer miscompares = 0, tests_run = 0, m_run = 0, m_trip = 0, i, n;
    reg [31:0] lfsr = 32'hFDEE7720;
    mscio_field mscio_field_i (.clk_sys(clk_sys), .start_req(sreq), .stop_req(preq),
        .olr_trip(otrip), .olr_reset(orst), .start_in(start_in), .stop_in(stop_in),
        .thermistor_loop_ok(loop_ok));
    mscio_top #(.DEBOUNCE_CYC(32'h4), .ATSPEED_CYC(32'h32)) mscio_top_i (
        .clk_sys(clk_sys), .nrst(nrst), .two_wire_mode(two_w), .start_in(start_in),
        .stop_in(stop_in), .interlock_in(ilk), .ramp_sel_in(rsel), .jog_in(jog),
        .thermistor_loop_ok(loop_ok), .reset_req(rreq), .decel_enable(decel),
        .decel_done(ddone), .end_of_ramp(eor), .current_dropped(cdrop), .ext_trip(etrip),
        .ext_trip_code(ecode), .serial_run_req(srun), .serial_control_mode_param(smode),
        .relay_one_function(fn1), .relay_two_function(`MSCIO_RLY2_DEFAULT),
        .relay_three_function(`MSCIO_RLY3_DEFAULT), .ramp_one_time(r1t), .ramp_one_curr(r1c),
        .ramp_two_time(10'h000), .ramp_two_curr(10'h258), .motor_power(motor_power),
        .ramping(ramping), .decelerating(decelerating), .full_voltage_start(fvs),
        .ramp_two_active(r2a), .jog_active(jog_active), .serial_enabled(ser_en),
        .at_speed(at_speed), .bypass_cmd(bypass_cmd), .fault_out(fault_out),
        .trip_code(trip_code), .aux_relay(aux));
    always #10 clk_sys = ~clk_sys;
    function [31:0] nxt(input [31:0] v);
        nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task wt(input integer c);
        repeat (c) @(posedge clk_sys);
        #1;
    endtask
    task check(input string nm, input [7:0] seen, input [7:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // outputs against the model state
    task cmp;
        check("motor_power", motor_power, m_run != 0 && m_trip == 0);
        check("trip_code", trip_code, m_trip[7:0]);
        check("fault_out", fault_out, m_trip != 0);
        check("aux_three", aux[2], m_trip >= 5);
        check("aux_one", aux[0], m_run != 0 && m_trip == 0);
    endtask
    task clr;
        rreq <= 1'b1;
        wt(12);
        rreq <= 1'b0;
        wt(2);
    endtask
    task give_verdict;
        if (miscompares == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // main sequence
    initial begin
        wt(6);
        nrst <= 1'b1;
        clr;
        cmp;
        sreq <= 1'b1;
        wt(12);
        sreq <= 1'b0;
        wt(12);
        m_run = 1;
        cmp;
        n = 0;
        while (at_speed !== 1'b1 && n < 200) begin
            wt(1);
            n = n + 1;
        end
        check("at_speed_wait", n < 60, 1);
        if (n >= 200)
            give_verdict;
        check("bypass", bypass_cmd, 1);
        check("aux_two", aux[1], 1);
        preq <= 1'b1;
        wt(12);
        preq <= 1'b0;
        m_run = 0;
        cmp;
        check("aux_two_stop", aux[1], 0);
        ilk <= 1'b0;
        sreq <= 1'b1;
        wt(12);
        sreq <= 1'b0;
        wt(12);
        cmp;
        ilk <= 1'b1;
        jog <= 1'b1;
        wt(12);
        cmp;
        sreq <= 1'b1;
        wt(12);
        check("jog_active", jog_active, 1);
        sreq <= 1'b0;
        preq <= 1'b1;
        wt(12);
        preq <= 1'b0;
        srun <= 1'b1;
        for (i = 0; i < 8; i = i + 1) begin
            smode <= i[2:1];
            jog <= i[0];
            wt(12);
            check("serial_en", ser_en, i / 2 == 1 || i == 5 || i == 6);
            check("serial_run", motor_power, i / 2 == 1 || i == 5 || i == 6);
        end
        srun <= 1'b0;
        jog <= 1'b0;
        two_w <= 1'b1;
        for (i = 0; i < 2; i = i + 1) begin
            lfsr = nxt(lfsr);
            r1t <= lfsr[9:0] | 10'h001;
            r1c <= lfsr[25:16];
            rsel <= i[0];
            wt(6);
            sreq <= 1'b1;
            wt(12);
            m_run = 1;
            cmp;
            check("ramp_two", r2a, i[7:0]);
            check("full_volt", fvs, i[7:0]);
            eor <= 1'b1;
            cdrop <= i[0];
            wt(2);
            check("early_speed", at_speed, i[7:0]);
            sreq <= 1'b0;
            wt(12);
            m_run = 0;
            cmp;
        end
        decel <= 1'b1;
        eor <= 1'b0;
        cdrop <= 1'b0;
        sreq <= 1'b1;
        wt(12);
        sreq <= 1'b0;
        wt(12);
        check("decel", decelerating, 1);
        check("aux_one_decel", aux[0], 0);
        otrip <= 1'b1;
        wt(12);
        otrip <= 1'b0;
        m_trip = 14;
        cmp;
        clr;
        cmp;
        orst <= 1'b1;
        wt(12);
        orst <= 1'b0;
        clr;
        m_trip = 0;
        cmp;
        for (i = 0; i < 4; i = i + 1) begin
            lfsr = nxt(lfsr);
            ecode <= (i == 0) ? 4'h3 : (lfsr[3:0] | 4'h1);
            etrip <= 1'b1;
            wt(12);
            m_trip = ecode;
            cmp;
            fn1 <= `MSCIO_FN_ANY_TRIP;
            wt(3);
            check("aux_one_fn", aux[0], 1);
            fn1 <= `MSCIO_FN_RUN;
            etrip <= 1'b0;
            clr;
            m_trip = 0;
            cmp;
        end
        sreq <= 1'b1;
        wt(12);
        sreq <= 1'b0;
        wt(12);
        check("decel_hold", decelerating, 1);
        ddone <= 1'b1;
        wt(2);
        ddone <= 1'b0;
        check("decel_end", decelerating, 0);
        cmp;
        give_verdict;
    end
endmodule // mscio_top_test
`default_nettype wire
